// *** rtl/did_params.svh ***
/*
  Constants for the DMA instruction dispatch block: instruction field
  positions, opcode pattern, increment step, register offsets, field
  layouts and reset values.
  Assumes inclusion by bare name from the package and the design file.
*/
`ifndef DID_PARAMS_SVH
`define DID_PARAMS_SVH

// ----------------------------------------------------------------------
// Instruction fields
// ----------------------------------------------------------------------
`define DID_OPC_HI 31
`define DID_OPC_LO 29
`define DID_OPC_DMA 3'h3
`define DID_PORT_BIT 28
`define DID_WRITE_BIT 27
`define DID_INC_BIT 26
`define DID_LEN_HI 26
`define DID_LEN_EXT_HI 25
`define DID_LEN_LO 19
`define DID_RLA_HI 18
`define DID_RLA_LO 14
`define DID_RSA_HI 13
`define DID_RSA_LO 10
`define DID_CTL_HI 9
`define DID_CTL_LO 5
`define DID_IBI_BIT 9
`define DID_CRCX_BIT 8
`define DID_CRCY_BIT 7
`define DID_RSB_HI 4
`define DID_RSB_LO 0

// ----------------------------------------------------------------------
// Buffer address advance
// ----------------------------------------------------------------------
`define DID_RLA_STEP 9'h040
`define DID_RLA_WRAP_HI 8

// ----------------------------------------------------------------------
// Register map
// ----------------------------------------------------------------------
`define DID_OFS_MODE 8'h00
`define DID_OFS_ALT 8'h04
`define DID_OFS_STATUS 8'h08
`define DID_MODE_EXT_BIT 5
`define DID_ALT_LEN_HI 7
`define DID_ALT_LEN_LO 0
`define DID_ALT_CRCX_BIT 8
`define DID_ALT_CRCY_BIT 9
`define DID_MODE_RST 32'h0000_0000
`define DID_ALT_RST 32'h0000_0000
`define DID_RESP_OKAY 2'h0
`define DID_RESP_SLVERR 2'h2

`endif

// *** rtl/did_pkg.sv ***
/*
  Types shared by the DMA instruction dispatch block.
  Assumes did_params.svh is on the include path.
*/
`include "did_params.svh"

package did_pkg;

  typedef logic [31:0] did_word_t;
  typedef logic [4:0] did_rla_sel_t;
  typedef logic [3:0] did_rsa_sel_t;
  typedef logic [4:0] did_rsb_sel_t;
  typedef logic [7:0] did_len_t;
  typedef logic [4:0] did_ctl_t;

endpackage

// *** rtl/did_dispatch.sv ***
/*
  DMA instruction decoder and dispatcher: decodes DMA opcodes from the
  issue stage, loads one request slot per port queue, and schedules the
  buffer address register advance as a delayed writeback.
  Assumes the pipeline reads rla_value from its register file for the
  presented instruction, retires one instruction per accepted cycle, and
  writes rla_wr_data at the edge that ends a cycle with rla_wr_en high.
*/
// Decided for this implementation: the address map and the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
`include "did_params.svh"

// What this block does
// - Opcode 011 in bits 31:29 is DMA; bits 28:27 pick port and direction.
// - Each dispatched DMA instruction loads one request into its port queue.
// - Buffer address, first and second source selects come from the word.
// - Advance buffer address by 64 modulo 512 when advancing applies.
// - Advancing is allowed only while the extended DMA mode bit is one.
// - Extended mode off: bit 26 is length MSB, no advance ever.
// - Extended mode on: bit 26 set advances at commit, clear leaves it.
// - The next instruction still reads the old buffer address.
// - The second following instruction may read old or new value.
// - From the third following instruction on, the new value is read.
// - The alternate length register may supply length and options.
// - Without an explicit length, length and checksum come from it.
// - Bits 9:5 of every DMA instruction form the control field.
module did_dispatch
  import did_pkg::*;
#(
  parameter int ADDR_W = 8
)
(
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic ce,
  input wire logic [31:0] instr,
  input wire logic instr_valid,
  output logic instr_ready,
  input wire did_word_t rla_value,
  output logic rla_wr_en,
  output did_rla_sel_t rla_wr_sel,
  output did_word_t rla_wr_data,
  output logic [1:0] q_valid,
  input wire logic [1:0] q_ready,
  output logic [1:0] q_write,
  output did_len_t [1:0] q_length,
  output did_ctl_t [1:0] q_control,
  output logic [1:0] q_crc_x,
  output logic [1:0] q_crc_y,
  output did_rla_sel_t [1:0] q_rla_sel,
  output did_rsa_sel_t [1:0] q_rsa_sel,
  output did_rsb_sel_t [1:0] q_rsb_sel,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  generate
    if (ADDR_W < 4)
    begin : g_bad_addr
      $error("did_dispatch: ADDR_W must be at least 4");
    end
  endgenerate

  // ----------------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------------
  did_word_t mode_reg;
  did_word_t alt_reg;
  logic is_dma;
  logic port;
  logic ext_en;
  logic inc;
  logic accept;
  logic dispatch;
  logic [1:0] slot_free;
  did_len_t next_len;
  logic next_crc_x;
  logic next_crc_y;
  logic [8:0] next_rla_low;

  always_comb
  begin
    is_dma = instr[`DID_OPC_HI:`DID_OPC_LO] == `DID_OPC_DMA;
    port = instr[`DID_PORT_BIT];
    ext_en = mode_reg[`DID_MODE_EXT_BIT];
    inc = is_dma && ext_en && instr[`DID_INC_BIT];
    if (!instr[`DID_IBI_BIT])
    begin
      next_len = alt_reg[`DID_ALT_LEN_HI:`DID_ALT_LEN_LO];
      next_crc_x = alt_reg[`DID_ALT_CRCX_BIT];
      next_crc_y = alt_reg[`DID_ALT_CRCY_BIT];
    end
    else
    begin
      if (ext_en)
        next_len = {1'b0, instr[`DID_LEN_EXT_HI:`DID_LEN_LO]};
      else
        next_len = instr[`DID_LEN_HI:`DID_LEN_LO];
      next_crc_x = instr[`DID_CRCX_BIT];
      next_crc_y = instr[`DID_CRCY_BIT];
    end
    // Nine-bit sum wraps at 512 by itself
    next_rla_low = rla_value[`DID_RLA_WRAP_HI:0] + `DID_RLA_STEP;
  end

  assign slot_free = ~q_valid | q_ready;
  // Non-DMA words are consumed at once with no effect
  assign instr_ready = ce && (!is_dma || slot_free[port]);
  assign accept = instr_valid && instr_ready;
  assign dispatch = accept && is_dma;

  // ----------------------------------------------------------------------
  // Port request slots
  // ----------------------------------------------------------------------
  genvar p;
  generate
    for (p = 0; p < 2; p++)
    begin : g_port
      logic hit;
      assign hit = dispatch && (port == 1'(p));

      always_ff @(posedge clk_sys)
      begin
        if (srst)
          q_valid[p] <= 1'b0;
        else if (ce)
        begin
          if (hit)
            q_valid[p] <= 1'b1;
          else if (q_ready[p])
            q_valid[p] <= 1'b0;
        end
      end

      always_ff @(posedge clk_sys)
      begin
        if (srst)
        begin
          q_write[p] <= 1'b0;
          q_length[p] <= '0;
          q_control[p] <= '0;
          q_crc_x[p] <= 1'b0;
          q_crc_y[p] <= 1'b0;
          q_rla_sel[p] <= '0;
          q_rsa_sel[p] <= '0;
          q_rsb_sel[p] <= '0;
        end
        else if (ce && hit)
        begin
          q_write[p] <= instr[`DID_WRITE_BIT];
          q_length[p] <= next_len;
          q_control[p] <= instr[`DID_CTL_HI:`DID_CTL_LO];
          q_crc_x[p] <= next_crc_x;
          q_crc_y[p] <= next_crc_y;
          q_rla_sel[p] <= instr[`DID_RLA_HI:`DID_RLA_LO];
          q_rsa_sel[p] <= instr[`DID_RSA_HI:`DID_RSA_LO];
          q_rsb_sel[p] <= instr[`DID_RSB_HI:`DID_RSB_LO];
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------------
  // Buffer address advance
  // ----------------------------------------------------------------------
  // Two stages so the following instruction still reads the old value;
  // the write lands at the edge that retires the second follower, which
  // therefore may see either value under stalls.
  logic s1_vld;
  did_rla_sel_t s1_sel;
  did_word_t s1_data;

  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      s1_vld <= 1'b0;
      s1_sel <= '0;
      s1_data <= '0;
    end
    else if (ce)
    begin
      s1_vld <= dispatch && inc;
      if (dispatch && inc)
      begin
        s1_sel <= instr[`DID_RLA_HI:`DID_RLA_LO];
        s1_data <= {rla_value[31:`DID_RLA_WRAP_HI+1], next_rla_low};
      end
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      rla_wr_en <= 1'b0;
      rla_wr_sel <= '0;
      rla_wr_data <= '0;
    end
    else if (ce)
    begin
      rla_wr_en <= s1_vld;
      rla_wr_sel <= s1_sel;
      rla_wr_data <= s1_data;
    end
  end

  // ----------------------------------------------------------------------
  // AXI4-Lite slave
  // ----------------------------------------------------------------------
  logic aw_hold;
  logic w_hold;
  logic [ADDR_W-1:0] aw_addr;
  did_word_t w_data;
  logic [3:0] w_strb;
  logic [15:0] dispatch_cnt;
  logic do_write;

  assign s_axi_awready = ce && !aw_hold && !s_axi_bvalid;
  assign s_axi_wready = ce && !w_hold && !s_axi_bvalid;
  assign s_axi_arready = ce && !s_axi_rvalid;
  assign do_write = ce && aw_hold && w_hold && !s_axi_bvalid;

  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      aw_hold <= 1'b0;
      w_hold <= 1'b0;
      aw_addr <= '0;
      w_data <= '0;
      w_strb <= '0;
    end
    else if (ce)
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_hold <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      else if (do_write)
        aw_hold <= 1'b0;
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_hold <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      else if (do_write)
        w_hold <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      mode_reg <= `DID_MODE_RST;
      alt_reg <= `DID_ALT_RST;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `DID_RESP_OKAY;
    end
    else if (ce)
    begin
      if (do_write)
      begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= `DID_RESP_OKAY;
        if (aw_addr == ADDR_W'(`DID_OFS_MODE))
        begin
          for (int b = 0; b < 4; b++)
            if (w_strb[b])
              mode_reg[8*b +: 8] <= w_data[8*b +: 8];
        end
        else if (aw_addr == ADDR_W'(`DID_OFS_ALT))
        begin
          for (int b = 0; b < 4; b++)
            if (w_strb[b])
              alt_reg[8*b +: 8] <= w_data[8*b +: 8];
        end
        else if (aw_addr != ADDR_W'(`DID_OFS_STATUS))
          s_axi_bresp <= `DID_RESP_SLVERR;
      end
      else if (s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (srst)
      dispatch_cnt <= '0;
    else if (dispatch)
      dispatch_cnt <= dispatch_cnt + 16'h0001;
  end

  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= `DID_RESP_OKAY;
    end
    else if (ce)
    begin
      if (s_axi_arvalid && s_axi_arready)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= `DID_RESP_OKAY;
        if (s_axi_araddr == ADDR_W'(`DID_OFS_MODE))
          s_axi_rdata <= mode_reg;
        else if (s_axi_araddr == ADDR_W'(`DID_OFS_ALT))
          s_axi_rdata <= alt_reg;
        else if (s_axi_araddr == ADDR_W'(`DID_OFS_STATUS))
          s_axi_rdata <= {s1_vld, rla_wr_en, q_valid, 12'h000,
                          dispatch_cnt};
        else
        begin
          s_axi_rdata <= '0;
          s_axi_rresp <= `DID_RESP_SLVERR;
        end
      end
      else if (s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (srst);

  a_port_one_load: assert property (
    dispatch && !port |=> q_valid[0] && q_write[0] == $past(instr[27]))
    else $error("port one request not loaded");

  a_port_two_load: assert property (
    dispatch && port |=> q_valid[1] && q_write[1] == $past(instr[27]))
    else $error("port two request not loaded");

  a_operand_fields: assert property (
    dispatch && !port |=> q_rla_sel[0] == $past(instr[18:14])
      && q_rsa_sel[0] == $past(instr[13:10])
      && q_rsb_sel[0] == $past(instr[4:0]))
    else $error("operand selects wrong");

  a_advance_value: assert property (
    dispatch && inc ##1 ce |=> rla_wr_en
      && rla_wr_data[8:0] == $past(rla_value[8:0], 2) + 9'h040)
    else $error("buffer address advance wrong");

  a_mode_gate: assert property (
    !mode_reg[5] && dispatch |=> !s1_vld)
    else $error("advance without extended mode");

  a_len_msb: assert property (
    dispatch && !ext_en && instr[9] && !port
      |=> q_length[0][7] == $past(instr[26]))
    else $error("bit 26 not used as length msb");

  a_bit_clear: assert property (
    dispatch && ext_en && !instr[26] |=> !s1_vld)
    else $error("advance with bit 26 clear");

  a_hold_old: assert property (
    dispatch && inc && !s1_vld |=> !rla_wr_en)
    else $error("advance visible too early");

  a_alt_length: assert property (
    dispatch && !instr[9] && !port |=> q_length[0] == $past(alt_reg[7:0])
      && q_crc_x[0] == $past(alt_reg[8]))
    else $error("alternate length not used");

  a_control_field: assert property (
    dispatch && port |=> q_control[1] == $past(instr[9:5]))
    else $error("control field wrong");

  a_non_dma_quiet: assert property (
    accept && !is_dma |=> !$rose(q_valid[0]) && !$rose(q_valid[1])
      && !s1_vld)
    else $error("non DMA word produced a request");

  c_advance: cover property (dispatch && inc ##2 rla_wr_en);
  c_alt_len: cover property (dispatch && !instr[9]);
  c_both_busy: cover property (q_valid == 2'b11);

endmodule

// *** tb/did_partner.sv ***
/*
  Far-side model: the pipeline register file that feeds rla_value and
  takes the delayed writeback, plus the two port queue consumers.
  Assumes the bench stalls a queue by raising its stall bit.
*/
`timescale 1ns/100ps
module did_partner
  import did_pkg::*;
(
  input wire logic clk_sys,
  input wire logic srst,
  input wire did_rla_sel_t rd_sel,
  output did_word_t rla_value,
  input wire logic rla_wr_en,
  input wire did_rla_sel_t rla_wr_sel,
  input wire did_word_t rla_wr_data,
  input wire logic [1:0] stall,
  output logic [1:0] q_ready
);
  // ----------------------------------------------------------------
  // Register file
  // ----------------------------------------------------------------
  did_word_t rf [32];

  // Low bits start near the wrap point so an advance crosses it
  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      for (int k = 0; k < 32; k++)
        rf[k] <= 32'h1000_01c0 + 32'(k);
    end
    else if (rla_wr_en)
      rf[rla_wr_sel] <= rla_wr_data;
  end

  // Read in the same cycle, as the issue stage does
  assign rla_value = rf[rd_sel];
  assign q_ready = ~stall;
endmodule

// *** tb/tb_top.sv ***
/*
  Self-checking bench for the DMA instruction dispatch block.
  Assumes did_pkg and the partner model are compiled first.
*/
`timescale 1ns/100ps
module tb_top
  import did_pkg::*;
;
  // ----------------------------------------------------------------
  // Signals and instances
  // ----------------------------------------------------------------
  logic clk_sys = 1'b0;
  logic srst = 1'b1;
  logic ce = 1'b1;
  logic [31:0] instr = '0;
  logic instr_valid = 1'b0;
  logic instr_ready, rla_wr_en;
  did_word_t rla_value, rla_wr_data;
  did_rla_sel_t rla_wr_sel;
  logic [1:0] stall = 2'h0;
  logic [1:0] q_valid, q_ready, q_write, q_crc_x, q_crc_y;
  did_len_t [1:0] q_length;
  did_ctl_t [1:0] q_control;
  did_rla_sel_t [1:0] q_rla_sel;
  did_rsa_sel_t [1:0] q_rsa_sel;
  did_rsb_sel_t [1:0] q_rsb_sel;
  logic [7:0] s_axi_awaddr = '0;
  logic [7:0] s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0;
  logic [31:0] s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 1'b0;
  logic s_axi_wvalid = 1'b0;
  logic s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0;
  logic s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  int n_errors = 0;
  int n_checks = 0;
  int cyc = 0;
  logic [31:0] d;
  logic [1:0] r;
  did_word_t s0, s1, s2, s3;

  always #50 clk_sys = ~clk_sys;

  did_dispatch DUT (.clk_sys, .srst, .ce, .instr, .instr_valid,
    .instr_ready, .rla_value, .rla_wr_en, .rla_wr_sel, .rla_wr_data,
    .q_valid, .q_ready, .q_write, .q_length, .q_control, .q_crc_x,
    .q_crc_y, .q_rla_sel, .q_rsa_sel, .q_rsb_sel, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);

  did_partner u_far (.clk_sys, .srst, .rd_sel(instr[18:14]),
    .rla_value, .rla_wr_en, .rla_wr_sel, .rla_wr_data, .stall,
    .q_ready);

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic report_and_stop;
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [39:0] s,
    input logic [39:0] e);
    n_checks++;
    if (s !== e)
    begin
      n_errors++;
      $display("[FAIL] %s exp %h seen %h", nm, e, s);
    end
  endtask

  // Hang guard: the whole sequence needs well under a thousand cycles
  always @(posedge clk_sys)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      n_errors++;
      report_and_stop();
    end
  end

  task automatic axw(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk_sys);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do
    begin
      @(posedge clk_sys);
      if (s_axi_awready)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wready)
        s_axi_wvalid <= 1'b0;
    end
    while (s_axi_bvalid !== 1'b1);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask

  task automatic axr(input logic [7:0] a);
    @(posedge clk_sys);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do
    begin
      @(posedge clk_sys);
      if (s_axi_arready)
        s_axi_arvalid <= 1'b0;
    end
    while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask

  // Leaves valid high so words can follow back to back
  task automatic issue(input did_word_t w, output did_word_t seen);
    instr <= w;
    instr_valid <= 1'b1;
    do
      @(posedge clk_sys);
    while (instr_ready !== 1'b1);
    seen = rla_value;
  endtask

  task automatic one(input did_word_t w);
    @(posedge clk_sys);
    issue(w, s0);
    instr_valid <= 1'b0;
    @(negedge clk_sys);
  endtask

  function automatic did_word_t mk(input logic [2:0] o,
    input logic [1:0] p, input logic b, input logic [6:0] l,
    input did_rla_sel_t a, input did_ctl_t c);
    return {o, p, b, l, a, 4'h9, c, 5'h15};
  endfunction

  function automatic did_word_t base(input int k);
    return 32'h1000_01c0 + 32'(k);
  endfunction

  // ----------------------------------------------------------------
  // Sequence
  // ----------------------------------------------------------------
  initial
  begin
    repeat (8) @(posedge clk_sys);
    srst <= 1'b0;
    axr(8'h00);
    chk("mode rst", d, 0);
    axw(8'h04, 32'h3ab);
    chk("alt resp", r, 2'h0);
    axr(8'h04);
    chk("alt", {r, d}, {2'h0, 32'h3ab});
    axr(8'h0c);
    chk("unmapped", {r, d}, {2'h2, 32'h0});
    axw(8'h0c, 32'h5);
    chk("wr unmapped", r, 2'h2);
    for (int p = 0; p < 4; p++)
    begin
      one(mk(3'h3, 2'(p), 1'b1, 7'h7f, 5'(p + 1), 5'h16));
      chk("port", {q_valid, q_write[p/2], q_crc_x[p/2], q_crc_y[p/2]},
        {2'h1 << (p / 2), p[0], 2'h1});
      chk("fields", {q_length[p/2], q_control[p/2], q_rla_sel[p/2],
        q_rsa_sel[p/2], q_rsb_sel[p/2]},
        {8'hff, 5'h16, 5'(p + 1), 4'h9, 5'h15});
    end
    one(mk(3'h3, 2'h0, 1'b0, 7'h05, 5'd2, 5'h00));
    chk("alt len", {q_length[0], q_crc_x[0], q_crc_y[0]},
      {8'hab, 2'h3});
    one(mk(3'h1, 2'h3, 1'b1, 7'h7f, 5'd1, 5'h1f));
    chk("non dma", q_valid, 0);
    axw(8'h00, 32'h20);
    axr(8'h00);
    chk("mode", d, 32'h20);
    one(mk(3'h3, 2'h3, 1'b0, 7'h12, 5'd8, 5'h10));
    chk("ext len", {q_valid, q_length[1]}, {2'h2, 8'h12});
    @(posedge clk_sys);
    issue(mk(3'h3, 2'h3, 1'b1, 7'h12, 5'd7, 5'h10), s0);
    issue(mk(3'h1, 2'h0, 1'b0, 7'h0, 5'd7, 5'h0), s1);
    issue(mk(3'h1, 2'h0, 1'b0, 7'h0, 5'd7, 5'h0), s2);
    issue(mk(3'h1, 2'h0, 1'b0, 7'h0, 5'd7, 5'h0), s3);
    chk("next old", s1, base(7));
    chk("third new", s3,
      {23'(base(7) >> 9), 9'(base(7) + 32'h40)});
    issue(mk(3'h1, 2'h0, 1'b0, 7'h0, 5'd8, 5'h0), s1);
    issue(mk(3'h1, 2'h0, 1'b0, 7'h0, 5'd1, 5'h0), s2);
    chk("no adv on", s1, base(8));
    chk("no adv off", s2, base(1));
    instr_valid <= 1'b0;
    stall <= 2'h1;
    one(mk(3'h3, 2'h0, 1'b0, 7'h03, 5'd9, 5'h10));
    @(posedge clk_sys);
    instr <= mk(3'h3, 2'h1, 1'b0, 7'h04, 5'd9, 5'h10);
    instr_valid <= 1'b1;
    repeat (3) @(posedge clk_sys);
    chk("refused", {instr_ready, q_valid}, {1'b0, 2'h1});
    stall <= 2'h0;
    issue(mk(3'h3, 2'h1, 1'b0, 7'h04, 5'd9, 5'h10), s0);
    instr_valid <= 1'b0;
    @(negedge clk_sys);
    chk("queued", {q_valid[0], q_write[0], q_length[0]},
      {2'h3, 8'h04});
    // Enable low must refuse a word and freeze the slots
    @(posedge clk_sys);
    ce <= 1'b0;
    instr <= mk(3'h3, 2'h2, 1'b0, 7'h01, 5'd3, 5'h10);
    instr_valid <= 1'b1;
    repeat (2) @(posedge clk_sys);
    chk("frozen", {instr_ready, q_valid}, 0);
    ce <= 1'b1;
    issue(mk(3'h3, 2'h2, 1'b0, 7'h01, 5'd3, 5'h10), s0);
    instr_valid <= 1'b0;
    // Ten DMA words dispatched; non-DMA and refused words not counted
    axr(8'h08);
    chk("status", {r, d}, {2'h0, 32'h0000_000a});
    report_and_stop();
  end
endmodule
